// *** scsfc_pkg.sv ***
//==================================================================
// Socket card force and control constants
//==================================================================
// Behaviour
// - Force register at 0Ch; upper bits read zero
// - Retest bit re-interrogates card, re-enables power control
// - Forced supply bits copy into capability flags
// - Forced supply one disables power control until retest
// - Forced bit 9 writes invalid-supply flag
// - Forced bits 8,7,5,4 write matching flags
// - Forced bit 3 sets power event only
// - Forced bits 2,1 set detect events only
// - Forced bit 0 sets status event only
// - Force bit 6 ignores writes, reads zero
// - Control register at 10h, resets zero, high zero
// - Policy zero: halt only idle and host halting
// - Policy one: halt whenever socket is idle
// - Program supply field decodes six codes, two reserved
// - Control bit 3 ignores writes, reads zero
// - Only acceptable supply requests reach the switch
// - Invalid supply request sets invalid-supply flag
// - Capability and type flags change only on force or interrogation
package scsfc_pkg;

  //==================================================================
  // Register offsets
  //==================================================================
  localparam logic [7:0] SCSFC_OFS_PRESENT = 8'h08;
  localparam logic [7:0] SCSFC_OFS_FORCE = 8'h0c;
  localparam logic [7:0] SCSFC_OFS_CTRL = 8'h10;

  //==================================================================
  // Force register bit positions
  //==================================================================
  localparam int FRC_RETEST = 14;
  localparam int FRC_CAP_HI = 13;
  localparam int FRC_CAP_LO = 10;
  localparam int FRC_BAD = 9;
  localparam int FRC_LOSS = 8;
  localparam int FRC_UNREC = 7;
  localparam int FRC_WIDE = 5;
  localparam int FRC_NARROW = 4;
  localparam int FRC_PWR = 3;
  localparam int FRC_EVT_HI = 3;

  //==================================================================
  // Control register layout and reset
  //==================================================================
  localparam int CTL_HALT = 7;
  localparam int CTL_VCC_HI = 6;
  localparam int CTL_VCC_LO = 4;
  localparam int CTL_VPP_HI = 2;
  localparam int CTL_VPP_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'hf7;

  //==================================================================
  // Present-state layout
  //==================================================================
  localparam logic [3:0] PRS_SOCK_CAPS = 4'h3;
  localparam int ST_W = 9;
  localparam int ST_CAP_LO = 5;
  localparam int ST_BAD = 4;
  localparam int ST_LOSS = 3;
  localparam int ST_UNREC = 2;
  localparam int ST_WIDE = 1;
  localparam int ST_NARROW = 0;
  localparam logic [8:0] ST_INTERROG_MASK = 9'h1e7;

  //==================================================================
  // Supply request codes
  //==================================================================
  typedef enum logic [2:0] {
    SUP_OFF = 3'h0,
    SUP_12V = 3'h1,
    SUP_5V = 3'h2,
    SUP_3V3 = 3'h3,
    SUP_XX = 3'h4,
    SUP_YY = 3'h5,
    SUP_RSV6 = 3'h6,
    SUP_RSV7 = 3'h7
  } scsfc_supply_t;

endpackage

// *** scsfc_present_state.sv ***
`timescale 1ns/1ps
//==================================================================
// Present-state flag store
//==================================================================
module scsfc_present_state
  import scsfc_pkg::*;
#(
  parameter int W = ST_W,
  parameter logic [8:0] UPD_MASK = ST_INTERROG_MASK
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Forced write
  input wire logic force_we_i,
  input wire logic [W-1:0] force_val_i,
  // Interrogation result
  input wire logic interrog_done_i,
  input wire logic [W-1:0] interrog_val_i,
  // Hardware set requests
  input wire logic [W-1:0] set_i,
  // Flags
  output logic [W-1:0] state_o
);

  logic [W-1:0] state_r; // Flag bits

  //==================================================================
  // One flip-flop per flag
  //==================================================================
  for (genvar i = 0; i < W; i++) begin : g_flag
    // Set wins, then force, then interrogation
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        state_r[i] <= 1'b0;
      end else if (set_i[i]) begin
        state_r[i] <= 1'b1;
      end else if (force_we_i) begin
        state_r[i] <= force_val_i[i];
      end else if (interrog_done_i && UPD_MASK[i]) begin
        state_r[i] <= interrog_val_i[i];
      end
    end
  end

  assign state_o = state_r;

endmodule // scsfc_present_state

// *** scsfc_supply_gate.sv ***
`timescale 1ns/1ps
//==================================================================
// Supply request check and switch drive
//==================================================================
module scsfc_supply_gate
  import scsfc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Request
  input wire logic eval_i,
  input wire logic enable_i,
  input wire logic [2:0] vcc_req_i,
  input wire logic [2:0] vpp_req_i,
  input wire logic [3:0] caps_i,
  // Switch drive and verdict
  output logic [2:0] switch_vcc_o,
  output logic [2:0] switch_vpp_o,
  output logic invalid_o
);

  logic [2:0] vcc_r; // Applied main supply
  logic [2:0] vpp_r; // Applied program supply
  logic invalid_r; // One-cycle invalid verdict

  // Card must list the voltage; off and 12 V always fine
  function automatic logic cap_ok(input logic [2:0] code, input logic [3:0] caps);
    case (scsfc_supply_t'(code))
      SUP_OFF: cap_ok = 1'b1;
      SUP_12V: cap_ok = 1'b1;
      SUP_5V: cap_ok = caps[0];
      SUP_3V3: cap_ok = caps[1];
      SUP_XX: cap_ok = caps[2];
      SUP_YY: cap_ok = caps[3];
      default: cap_ok = 1'b0;
    endcase
  endfunction

  // Main supply never takes the 12 V code
  wire vcc_ok = (vcc_req_i != SUP_12V) && cap_ok(vcc_req_i, caps_i);
  wire vpp_ok = cap_ok(vpp_req_i, caps_i);
  wire req_ok = vcc_ok && vpp_ok;

  //==================================================================
  // Pass only acceptable requests
  //==================================================================
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vcc_r <= 3'h0;
      vpp_r <= 3'h0;
      invalid_r <= 1'b0;
    end else begin
      invalid_r <= eval_i && !req_ok;
      if (eval_i && enable_i && req_ok) begin
        vcc_r <= vcc_req_i;
        vpp_r <= vpp_req_i;
      end
    end
  end

  assign switch_vcc_o = vcc_r;
  assign switch_vpp_o = vpp_r;
  assign invalid_o = invalid_r;

endmodule // scsfc_supply_gate

// *** scsfc_socket_regs.sv ***
`timescale 1ns/1ps
//==================================================================
// Socket force and control register block
//==================================================================
module scsfc_socket_regs
  import scsfc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Card interrogation
  output logic interrog_req_o,
  input wire logic interrog_done_i,
  input wire logic [3:0] interrog_caps_i,
  input wire logic interrog_unrec_i,
  input wire logic interrog_wide_i,
  input wire logic interrog_narrow_i,
  // Socket status
  input wire logic removal_loss_i,
  input wire logic socket_powered_i,
  input wire logic detect_a_pin_i,
  input wire logic detect_b_pin_i,
  input wire logic status_change_pin_i,
  input wire logic ready_pin_i,
  // Event pulses
  output logic power_change_event_o,
  output logic detect_b_change_event_o,
  output logic detect_a_change_event_o,
  output logic status_change_event_o,
  // Power switch
  output logic power_ctrl_en_o,
  output logic [2:0] switch_vcc_o,
  output logic [2:0] switch_vpp_o,
  // Card clock run
  input wire logic card_idle_i,
  input wire logic pci_clk_stopping_i,
  output logic card_clk_stop_allow_o
);

  //==================================================================
  // Declarations
  //==================================================================
  logic [3:0] sync1_r; // First synchroniser stage
  logic [3:0] sync2_r; // Second synchroniser stage
  logic [7:0] ctrl_r; // Socket control register
  logic [7:0] ctrl_nxt; // Next control value
  logic eval_r; // Check request next cycle
  logic pwr_en_r; // Power control enabled
  logic interrog_r; // Interrogation request pulse
  logic [3:0] evt_r; // Event pulses
  logic [31:0] rdata_r; // Read data
  logic [31:0] rdata_nxt; // Next read data
  logic [ST_W-1:0] state; // Present-state flags
  logic bad_req; // Invalid request verdict

  //==================================================================
  // Address decode
  //==================================================================
  wire force_wr = reg_wr_i && (reg_addr_i == SCSFC_OFS_FORCE);
  wire ctrl_wr = reg_wr_i && (reg_addr_i == SCSFC_OFS_CTRL);
  wire prs_rd = reg_addr_i == SCSFC_OFS_PRESENT;
  wire ctrl_rd = reg_addr_i == SCSFC_OFS_CTRL;

  // Write data fields
  wire retest = reg_wdata_i[FRC_RETEST];
  wire [3:0] force_caps = reg_wdata_i[FRC_CAP_HI:FRC_CAP_LO];
  wire [3:0] caps = state[ST_W-1:ST_CAP_LO];

  // Forced values, bit 6 of the write is dropped
  wire [ST_W-1:0] force_val = {force_caps, reg_wdata_i[FRC_BAD], reg_wdata_i[FRC_LOSS],
    reg_wdata_i[FRC_UNREC], reg_wdata_i[FRC_WIDE], reg_wdata_i[FRC_NARROW]};

  // Interrogation result; bad and loss slots unused
  wire [ST_W-1:0] interrog_val = {interrog_caps_i, 2'b00, interrog_unrec_i,
    interrog_wide_i, interrog_narrow_i};

  // Hardware set requests, winning over writes
  wire [ST_W-1:0] set_vec = {4'h0, bad_req, removal_loss_i, 3'h0};

  //==================================================================
  // Pin synchronisers
  //==================================================================
  // Only stage two feeds the read word
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {ready_pin_i, detect_b_pin_i, detect_a_pin_i, status_change_pin_i};
      sync2_r <= sync1_r;
    end
  end

  //==================================================================
  // Socket control register
  //==================================================================
  // Reserved bits masked off on write
  assign ctrl_nxt = ctrl_wr ? (reg_wdata_i[7:0] & CTL_WMASK) : ctrl_r;

  // Check strobe trails the write by one cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= CTL_RESET;
      eval_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      eval_r <= ctrl_wr;
    end
  end

  //==================================================================
  // Power control enable and interrogation request
  //==================================================================
  // Retest wins over a forced supply bit in the same write
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_en_r <= 1'b1;
      interrog_r <= 1'b0;
    end else begin
      interrog_r <= force_wr && retest;
      if (force_wr && retest) begin
        pwr_en_r <= 1'b1;
      end else if (force_wr && (|force_caps)) begin
        pwr_en_r <= 1'b0;
      end
    end
  end

  //==================================================================
  // Forced event pulses
  //==================================================================
  // Live status inputs are never touched here
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_r <= 4'h0;
    end else begin
      evt_r <= force_wr ? reg_wdata_i[FRC_EVT_HI:0] : 4'h0;
    end
  end

  //==================================================================
  // Flag store and supply gate
  //==================================================================
  // Set requests win over forced writes
  scsfc_present_state #(
    .W(ST_W),
    .UPD_MASK(ST_INTERROG_MASK)
  ) u_state (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .force_we_i(force_wr),
    .force_val_i(force_val),
    .interrog_done_i(interrog_done_i),
    .interrog_val_i(interrog_val),
    .set_i(set_vec),
    .state_o(state)
  );

  // Control write checked one cycle later
  scsfc_supply_gate u_gate (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .eval_i(eval_r),
    .enable_i(pwr_en_r),
    .vcc_req_i(ctrl_r[CTL_VCC_HI:CTL_VCC_LO]),
    .vpp_req_i(ctrl_r[CTL_VPP_HI:CTL_VPP_LO]),
    .caps_i(caps),
    .switch_vcc_o(switch_vcc_o),
    .switch_vpp_o(switch_vpp_o),
    .invalid_o(bad_req)
  );

  //==================================================================
  // Read path
  //==================================================================
  // Ready pin sits between unrecognised and wide flags
  wire [31:0] prs_word = {PRS_SOCK_CAPS, 14'h0, state[ST_W-1:ST_UNREC], sync2_r[3],
    state[ST_WIDE], state[ST_NARROW], socket_powered_i, sync2_r[2:0]};
  // Force register and unmapped offsets read zero
  assign rdata_nxt = prs_rd ? prs_word : (ctrl_rd ? {24'h0, ctrl_r} : 32'h0);

  // Read data held until the next read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0;
    end else if (reg_rd_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  //==================================================================
  // Outputs
  //==================================================================
  // Registered outputs straight from flops
  assign reg_rdata_o = rdata_r;
  assign interrog_req_o = interrog_r;
  assign power_ctrl_en_o = pwr_en_r;

  // Event pulses, one cycle each
  assign {power_change_event_o, detect_b_change_event_o, detect_a_change_event_o,
    status_change_event_o} = evt_r;

  // Halt policy: free when set, else follow the host clock
  assign card_clk_stop_allow_o = card_idle_i && (ctrl_r[CTL_HALT] || pci_clk_stopping_i);

  //==================================================================
  // Assertions
  //==================================================================
  // One clock domain; checks pause while in reset
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Force register write strobe
  sequence s_force_wr;
    force_wr;
  endsequence

  // Control write carrying a reserved program code
  sequence s_bad_vpp_wr;
    ctrl_wr && (reg_wdata_i[2:1] == 2'b11);
  endsequence

  // Verdict from the gate, then the stored flag
  sequence s_flag_raised;
    bad_req ##1 state[ST_BAD];
  endsequence

  // Write-only register reads back as zero
  AST_FORCE_READ_ZERO: assert property (reg_rd_i && reg_addr_i == SCSFC_OFS_FORCE
    |=> reg_rdata_o == 32'h0) else $error("force register read not zero");

  // Retest request is a single pulse and re-enables power
  AST_RETEST: assert property (s_force_wr and retest
    |=> interrog_req_o && power_ctrl_en_o) else $error("retest did not act");
  AST_REQ_PULSE: assert property (interrog_req_o && !(force_wr && retest)
    |=> !interrog_req_o) else $error("retest request held");

  // Forced values reach the flag store
  AST_CAP_COPY: assert property (s_force_wr
    |=> caps == $past(force_caps)) else $error("forced capability not copied");
  AST_BAD_COPY: assert property (s_force_wr and !bad_req
    |=> state[ST_BAD] == $past(reg_wdata_i[FRC_BAD])) else $error("invalid flag not written");
  AST_FLAG_COPY: assert property (s_force_wr and !removal_loss_i
    |=> state[ST_LOSS:0] == $past(force_val[ST_LOSS:0])) else $error("flags not written");

  // Forced supply bits lock power control until retest
  AST_PWR_OFF: assert property (s_force_wr and (|force_caps) and !retest
    |=> !power_ctrl_en_o) else $error("power control not disabled");
  AST_PWR_HOLD: assert property (!power_ctrl_en_o && !(force_wr && retest)
    |=> !power_ctrl_en_o) else $error("power control re-enabled without retest");

  // Forced events pulse for one cycle
  AST_PWR_EVENT: assert property (s_force_wr and reg_wdata_i[FRC_PWR]
    |=> power_change_event_o) else $error("power event not raised");
  AST_DETECT_EVENTS: assert property (s_force_wr
    |=> {detect_b_change_event_o, detect_a_change_event_o} == $past(reg_wdata_i[2:1]))
    else $error("detect events wrong");
  AST_STATUS_SET: assert property (s_force_wr and reg_wdata_i[0]
    |=> status_change_event_o) else $error("status event not raised");
  AST_STATUS_EVENT: assert property (!force_wr
    |=> !status_change_event_o && !power_change_event_o) else $error("spurious event");

  // Live status bits come from the pins, never from a force
  AST_LIVE_KEPT: assert property (reg_rd_i && prs_rd
    |=> reg_rdata_o[3:0] == {$past(socket_powered_i), $past(sync2_r[2:0])})
    else $error("live status bits disturbed");

  // Control register reads back the stored value
  AST_CTRL_READ: assert property (reg_rd_i && ctrl_rd
    |=> reg_rdata_o == {24'h0, $past(ctrl_r)}) else $error("control read wrong");
  AST_CTRL_RSVD: assert property (reg_rd_i && ctrl_rd
    |=> reg_rdata_o[31:8] == 24'h0 && !reg_rdata_o[3]) else $error("control reserved set");
  AST_VCC_FIELD: assert property (ctrl_wr
    |=> ctrl_r[CTL_VCC_HI:CTL_VCC_LO] == $past(reg_wdata_i[6:4])) else $error("vcc field lost");

  // Card clock halt policy
  AST_HALT_GUARD: assert property (card_clk_stop_allow_o
    |-> card_idle_i && (ctrl_r[CTL_HALT] || pci_clk_stopping_i)) else $error("halt not allowed");
  AST_HALT_FREE: assert property (ctrl_r[CTL_HALT] && card_idle_i
    |-> card_clk_stop_allow_o) else $error("idle halt blocked");
  AST_HALT_BLOCK: assert property (!ctrl_r[CTL_HALT] && !pci_clk_stopping_i
    |-> !card_clk_stop_allow_o) else $error("halt allowed while host clock runs");

  // Only acceptable requests reach the power switch
  AST_VPP_LEGAL: assert property (switch_vpp_o < SUP_RSV6)
    else $error("reserved program supply applied");
  AST_VCC_LEGAL: assert property (switch_vcc_o != SUP_12V && switch_vcc_o < SUP_RSV6)
    else $error("unacceptable main supply applied");
  AST_SWITCH_GATE: assert property ($changed(switch_vcc_o) || $changed(switch_vpp_o)
    |-> $past(eval_r && pwr_en_r)) else $error("switch changed without accepted request");
  AST_INVALID_FLAG: assert property (s_bad_vpp_wr |=> ##1 s_flag_raised)
    else $error("invalid request not flagged");

  // Card flags move only on force or interrogation
  AST_CAPS_STABLE: assert property (!force_wr && !interrog_done_i
    |=> $stable(caps) && $stable(state[ST_UNREC:0])) else $error("flags moved unprompted");

endmodule // scsfc_socket_regs

// *** scsfc_card_model.sv ***
`timescale 1ns/1ps
//==================================================================
// Card in socket answering interrogation
//==================================================================
module scsfc_card_model #(
  parameter logic [3:0] CAPS = 4'h3
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Interrogation handshake
  input wire logic interrog_req_i,
  input wire logic slow_i,
  output logic interrog_done_o,
  // Card identity lines
  output logic [3:0] caps_o,
  output logic unrec_o,
  output logic wide_o,
  output logic narrow_o
);
  logic [3:0] wait_r; // Cycles left before answer
  logic busy_r; // Interrogation in progress
  // Identity valid only with done, inverted otherwise
  assign caps_o = interrog_done_o ? CAPS : ~CAPS;
  assign wide_o = interrog_done_o;
  assign unrec_o = ~interrog_done_o;
  assign narrow_o = ~interrog_done_o;
  //==================================================================
  // Answer a request after a short or long delay
  //==================================================================
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      interrog_done_o <= 1'b0;
    end else begin
      interrog_done_o <= busy_r && (wait_r == 4'h0);
      if (interrog_req_i) begin
        busy_r <= 1'b1;
        wait_r <= slow_i ? 4'h7 : 4'h1;
      end else if (busy_r && wait_r == 4'h0) begin
        busy_r <= 1'b0;
      end else if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule // scsfc_card_model

// *** tb_card_socket_force_and_control.sv ***
`timescale 1ns/1ps
//==================================================================
// Bench for socket force and control registers
//==================================================================
module tb_card_socket_force_and_control;
  import scsfc_pkg::*;
  logic core_clk_i, rst_i; // Clock and reset
  logic reg_wr_i, reg_rd_i; // Register strobes
  logic [7:0] reg_addr_i; // Register offset
  logic [31:0] reg_wdata_i, reg_rdata_o; // Register data
  logic req, done, unrec, wide, narrow, slow; // Interrogation
  logic [3:0] caps; // Card supply caps
  logic loss, powered, det_a, det_b, sts, ready; // Socket status
  logic ev_p, ev_b, ev_a, ev_s; // Event pulses
  logic pwr_en, idle, stopping, allow; // Power and clock run
  logic [2:0] sw_vcc, sw_vpp; // Switch codes
  int errors, checks; // Counters
  //==================================================================
  // Design and card
  //==================================================================
  scsfc_socket_regs DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .interrog_req_o(req), .interrog_done_i(done),
    .interrog_caps_i(caps), .interrog_unrec_i(unrec), .interrog_wide_i(wide),
    .interrog_narrow_i(narrow), .removal_loss_i(loss), .socket_powered_i(powered),
    .detect_a_pin_i(det_a), .detect_b_pin_i(det_b), .status_change_pin_i(sts),
    .ready_pin_i(ready), .power_change_event_o(ev_p), .detect_b_change_event_o(ev_b),
    .detect_a_change_event_o(ev_a), .status_change_event_o(ev_s),
    .power_ctrl_en_o(pwr_en), .switch_vcc_o(sw_vcc), .switch_vpp_o(sw_vpp),
    .card_idle_i(idle), .pci_clk_stopping_i(stopping), .card_clk_stop_allow_o(allow));
  scsfc_card_model card (.core_clk_i(core_clk_i), .rst_i(rst_i), .interrog_req_i(req),
    .slow_i(slow), .interrog_done_o(done), .caps_o(caps), .unrec_o(unrec),
    .wide_o(wide), .narrow_o(narrow));
  //==================================================================
  // Shared tasks
  //==================================================================
  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  // One register read, compared
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk($sformatf("read %h", a), exp, reg_rdata_o);
  endtask
  // Idle for some cycles
  task automatic idle_for(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // Retest write, then wait for the card to answer
  task automatic retest(input logic s);
    int n;
    n = 0;
    @(posedge core_clk_i);
    slow <= s;
    wr(SCSFC_OFS_FORCE, 32'h0000_4000);
    chk("interrog_req", 32'h1, {31'h0, req});
    while (done !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n == 20) begin
      errors++;
      complete_run();
    end
    idle_for(1);
    chk("power_ctrl_en", 32'h1, {31'h0, pwr_en});
  endtask
  //==================================================================
  // Scenarios
  //==================================================================
  // Values after reset
  task automatic reset_check();
    chk("switch", 32'h0, {26'h0, sw_vcc, sw_vpp});
    rdchk(SCSFC_OFS_FORCE, 32'h0);
    rdchk(SCSFC_OFS_CTRL, 32'h0);
    rdchk(SCSFC_OFS_PRESENT, 32'h3000_0000);
  endtask
  // Prompt and slow interrogation load flags
  task automatic retest_check();
    retest(1'b0);
    rdchk(SCSFC_OFS_PRESENT, 32'h3000_0c20);
    retest(1'b1);
    rdchk(SCSFC_OFS_PRESENT, 32'h3000_0c20);
  endtask
  // Every program supply code against caps 0011
  task automatic supply_check();
    logic bad;
    bad = 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(SCSFC_OFS_CTRL, 32'(c));
      idle_for(3);
      bad = bad | (c > 3);
      chk("switch_vpp", (c > 3) ? 32'h3 : 32'(c), {29'h0, sw_vpp});
      rdchk(SCSFC_OFS_PRESENT, 32'h3000_0c20 | {22'h0, bad, 9'h0});
    end
    wr(SCSFC_OFS_CTRL, 32'h0000_0020);
    idle_for(3);
    chk("switch_vcc", 32'h2, {29'h0, sw_vcc});
    wr(SCSFC_OFS_CTRL, 32'h0000_0010);
    idle_for(3);
    chk("switch_vcc", 32'h2, {29'h0, sw_vcc});
    wr(SCSFC_OFS_CTRL, 32'h0);
    idle_for(3);
  endtask
  // Forced flags, power control lockout, clear and re-enable
  task automatic force_flags_check();
    wr(SCSFC_OFS_FORCE, 32'h0000_2bf0);
    chk("events", 32'h0, {28'h0, ev_p, ev_b, ev_a, ev_s});
    chk("power_ctrl_en", 32'h0, {31'h0, pwr_en});
    rdchk(SCSFC_OFS_PRESENT, 32'h3000_2bb0);
    wr(SCSFC_OFS_CTRL, 32'h1);
    idle_for(3);
    chk("switch_vpp", 32'h0, {29'h0, sw_vpp});
    wr(SCSFC_OFS_CTRL, 32'h0);
    rdchk(SCSFC_OFS_FORCE, 32'h0);
    wr(SCSFC_OFS_FORCE, 32'h0);
    rdchk(SCSFC_OFS_PRESENT, 32'h3000_0000);
    chk("power_ctrl_en", 32'h0, {31'h0, pwr_en});
    retest(1'b0);
    rdchk(SCSFC_OFS_PRESENT, 32'h3000_0c20);
  endtask
  // Each event bit pulses once, live bits untouched
  task automatic event_check();
    @(posedge core_clk_i);
    powered <= 1'b1;
    det_a <= 1'b1;
    sts <= 1'b1;
    ready <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(SCSFC_OFS_FORCE, 32'h1 << i);
      chk("events", 32'h1 << i, {28'h0, ev_p, ev_b, ev_a, ev_s});
      idle_for(1);
      chk("events", 32'h0, {28'h0, ev_p, ev_b, ev_a, ev_s});
    end
    rdchk(SCSFC_OFS_PRESENT, 32'h3000_004b);
    @(posedge core_clk_i);
    loss <= 1'b1;
    @(posedge core_clk_i);
    loss <= 1'b0;
    rdchk(SCSFC_OFS_PRESENT, 32'h3000_014b);
  endtask
  // Clock halt policy, reserved bits, unmapped offset
  task automatic ctrl_check();
    for (int i = 0; i < 8; i++) begin
      wr(SCSFC_OFS_CTRL, {24'h0, i[2], 7'h0});
      @(posedge core_clk_i);
      idle <= i[1];
      stopping <= i[0];
      idle_for(1);
      chk("stop_allow", {31'h0, i[1] & (i[2] | i[0])}, {31'h0, allow});
    end
    wr(SCSFC_OFS_CTRL, 32'hffff_ffff);
    rdchk(SCSFC_OFS_CTRL, 32'h0000_00f7);
    wr(8'h14, 32'hffff_ffff);
    rdchk(8'h14, 32'h0);
  endtask
  //==================================================================
  // Clock and main sequence
  //==================================================================
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {1'b1, 42'h0};
    {slow, loss, powered, det_a, det_b, sts, ready, idle, stopping} = 9'h0;
    errors = 0;
    checks = 0;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    idle_for(1);
    reset_check();
    retest_check();
    supply_check();
    force_flags_check();
    event_check();
    ctrl_check();
    complete_run();
  end
endmodule // tb_card_socket_force_and_control
